// File: common/rtca_pkg.sv
// constants and types shared by the oscillator, timer buffer and match value register set
package rtca_pkg;

  // apb address layout: register index sits in paddr[5:2], byte address = index * 4
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 5;

  // register indices
  localparam logic [3:0] IDX_SNAP0 = 4'h0;
  localparam logic [3:0] IDX_SNAP1 = 4'h1;
  localparam logic [3:0] IDX_SNAP2 = 4'h2;
  localparam logic [3:0] IDX_SNAP3 = 4'h3;
  localparam logic [3:0] IDX_OSC_CTRL = 4'h5;
  localparam logic [3:0] IDX_LOAD_CFG = 4'h6;
  localparam logic [3:0] IDX_PIN_CFG = 4'h7;
  localparam logic [3:0] IDX_MATCH0 = 4'h8;
  localparam logic [3:0] IDX_MATCH1 = 4'h9;
  localparam logic [3:0] IDX_MATCH2 = 4'hA;
  localparam logic [3:0] IDX_MATCH3 = 4'hB;
  localparam logic [3:0] IDX_TIMER_REQ = 4'hC;

  // oscillator control fields
  localparam int unsigned OSC_GAIN_BIT = 7;
  localparam int unsigned OSC_MODE_BIT = 6;
  localparam int unsigned OSC_BIAS_BIT = 5;
  localparam int unsigned OSC_VALID_BIT = 4;
  localparam int unsigned OSC_LFO_BIT = 3;
  localparam logic [7:0] OSC_WR_MASK = 8'hE8;
  localparam logic [7:0] OSC_RD_ZERO = 8'h07;

  // load capacitance configuration fields
  localparam int unsigned CFG_STEP_BIT = 7;
  localparam int unsigned CFG_READY_BIT = 6;
  localparam int unsigned CAP_W = 4;

  // pin configuration and timer request fields
  localparam int unsigned PIN_SHORT_BIT = 7;
  localparam int unsigned REQ_COPY_BIT = 0;
  localparam int unsigned REQ_SET_BIT = 1;
  localparam int unsigned REQ_MATCH_BIT = 2;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_CAP = 4'h0;

  // internal slow oscillator present on this variant
  localparam logic LFO_PRESENT = 1'b1;

  // load capacitance step interval
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned LOAD_STEP_NS = 1000;
  localparam int unsigned LOAD_STEP_CYC = (LOAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_CNT_W = 8;
  localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(LOAD_STEP_CYC - 1);
  localparam logic [STEP_CNT_W-1:0] STEP_ZERO = 8'h00;

  // timer transfer engine states
  typedef enum logic [2:0] {
    XF_IDLE = 3'b001,
    XF_LOAD = 3'b010,
    XF_COPY = 3'b100
  } rtca_xfer_t;

endpackage : rtca_pkg

// File: design/rtca_regs.sv
// oscillator control, load capacitance, pin short, timer buffer and match value registers
`timescale 1ns/1ps
`default_nettype none

module rtca_regs
  import rtca_pkg::*;
(
  input wire logic mclk,                     // 125 MHz clock
  input wire logic rst_n,                    // synchronous reset, active low
  input wire logic clkEn,                    // freezes all state while low
  input wire logic psel,                     // apb select
  input wire logic penable,                  // apb access phase
  input wire logic pwrite,                   // apb direction, 1 = write
  input wire logic [ADDR_W-1:0] paddr,       // apb byte address
  input wire logic [DATA_W-1:0] pwdata,      // apb write data
  output logic [DATA_W-1:0] prdata,          // apb read data, registered
  output logic pready,                       // apb ready, no wait states
  output logic pslverr,                      // apb error on unmapped address
  input wire logic oscAmplitudeValid,        // analog amplitude detector, asynchronous
  output logic autoGainEnable,               // gain control enable to oscillator
  output logic oscModeSelect,                // 1 crystal, 0 self-oscillate
  output logic biasDoubleEnable,             // bias doubling to oscillator
  output logic lowFreqOscSelect,             // internal slow oscillator enabled and chosen
  output logic crystalSourceActive,          // crystal path is the clock source
  output logic crystalPinShort,              // shorts crystal_pin_a to crystal_pin_b
  output logic [CAP_W-1:0] loadCapSetting,   // load capacitance code applied now
  output logic [DATA_W-1:0] matchValue,      // 32-bit compare value to the timer
  output logic matchEventEnable,             // match event enable to the timer
  output logic [DATA_W-1:0] timerLoadValue,  // value to load into the timer
  output logic timerLoadReq,                 // asks the timer to take timerLoadValue
  output logic timerCopyReq,                 // asks the timer to present its count
  input wire logic [DATA_W-1:0] timerCountIn,// running timer count, same clock
  input wire logic timerXferAck              // timer completes the pending request
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [DATA_W-1:0] snap;          // timer buffer, byte 0 is lsb
    logic [DATA_W-1:0] match;         // match value, byte 0 is lsb
    logic gain;                       // gain control enable
    logic mode;                       // oscillator mode
    logic bias;                       // bias doubling
    logic internal_slow_oscillator;                        // slow oscillator select
    logic stepEn;                     // stepping enable
    logic [CAP_W-1:0] capTarget;      // programmed capacitance
    logic [CAP_W-1:0] capNow;         // applied capacitance
    logic [STEP_CNT_W-1:0] stepCnt;   // cycles since the last step
    logic [7:0] pin;                  // pin short bit plus reserved bits
    logic setReq;                     // load request pending
    logic copyReq;                    // copy request pending
    logic matchEn;                    // match event enable
    rtca_xfer_t xfer;                 // transfer engine state
    logic ampMeta;                    // synchroniser first stage
    logic ampSync;                    // synchroniser second stage
    logic [DATA_W-1:0] rdData;        // read data held for the access phase
    logic slvErr;                     // unmapped address seen in setup
  } rtca_state_t;

  rtca_state_t st_reg;  // registered state
  rtca_state_t st_next; // next state

  logic [3:0] idx;          // register index of the current address
  logic mapped;             // address decodes to a register
  logic setupRd;            // read setup cycle
  logic wrEn;               // write takes effect this edge
  logic [7:0] wrByte;       // low byte of write data
  logic capReady;           // applied capacitance equals target
  logic [DATA_W-1:0] rdVal; // read value of the addressed register

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  // alignment and upper bits must be clear, otherwise the access is unmapped
  always_comb begin
    idx = paddr[IDX_MSB:IDX_LSB];
    wrByte = pwdata[7:0];
    unique case (idx)
      IDX_SNAP0, IDX_SNAP1, IDX_SNAP2, IDX_SNAP3,
      IDX_OSC_CTRL, IDX_LOAD_CFG, IDX_PIN_CFG,
      IDX_MATCH0, IDX_MATCH1, IDX_MATCH2, IDX_MATCH3, IDX_TIMER_REQ: begin
        mapped = (paddr[IDX_LSB-1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_MSB+1] == 2'h0);
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    setupRd = psel && !penable && !pwrite;
    wrEn = psel && penable && pwrite && mapped;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux

  // unused and gap bits, other than the pin configuration reserved bits, are built from constant zeros so no write can reach them
  always_comb begin
    capReady = (st_reg.capNow == st_reg.capTarget);
    rdVal = RST_WORD;
    unique case (idx)
      IDX_SNAP0: rdVal[7:0] = st_reg.snap[7:0];
      IDX_SNAP1: rdVal[7:0] = st_reg.snap[15:8];
      IDX_SNAP2: rdVal[7:0] = st_reg.snap[23:16];
      IDX_SNAP3: rdVal[7:0] = st_reg.snap[31:24];
      IDX_OSC_CTRL: begin
        rdVal[OSC_GAIN_BIT] = st_reg.gain;
        rdVal[OSC_MODE_BIT] = st_reg.mode;
        rdVal[OSC_BIAS_BIT] = st_reg.bias;
        rdVal[OSC_VALID_BIT] = st_reg.ampSync;
        rdVal[OSC_LFO_BIT] = st_reg.internal_slow_oscillator;
      end
      IDX_LOAD_CFG: begin
        rdVal[CFG_STEP_BIT] = st_reg.stepEn;
        rdVal[CFG_READY_BIT] = capReady;
        rdVal[CAP_W-1:0] = st_reg.capTarget;
      end
      IDX_PIN_CFG: begin
        // the short bit is write-only; reserved bits read back as stored
        rdVal[PIN_SHORT_BIT-1:0] = st_reg.pin[PIN_SHORT_BIT-1:0];
      end
      IDX_MATCH0: rdVal[7:0] = st_reg.match[7:0];
      IDX_MATCH1: rdVal[7:0] = st_reg.match[15:8];
      IDX_MATCH2: rdVal[7:0] = st_reg.match[23:16];
      IDX_MATCH3: rdVal[7:0] = st_reg.match[31:24];
      IDX_TIMER_REQ: begin
        rdVal[REQ_COPY_BIT] = st_reg.copyReq;
        rdVal[REQ_SET_BIT] = st_reg.setReq;
        rdVal[REQ_MATCH_BIT] = st_reg.matchEn;
      end
      default: rdVal = RST_WORD;
    endcase
    if (!mapped) begin
      rdVal = RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;

    // amplitude detector is asynchronous: two stages before anything reads it
    st_next.ampMeta = oscAmplitudeValid;
    st_next.ampSync = st_reg.ampMeta;

    // read data is sampled in setup so the access phase needs no wait state
    if (setupRd) begin
      st_next.rdData = rdVal;
    end
    if (psel && !penable) begin
      st_next.slvErr = !mapped;
    end

    // transfer engine; completion clears first so a new request in the same edge wins
    unique case (st_reg.xfer)
      XF_IDLE: begin
        if (st_reg.setReq) begin
          st_next.xfer = XF_LOAD;
        end else if (st_reg.copyReq) begin
          st_next.xfer = XF_COPY;
        end
      end
      XF_LOAD: begin
        if (timerXferAck) begin
          st_next.setReq = 1'b0;
          st_next.xfer = XF_IDLE;
        end
      end
      XF_COPY: begin
        if (timerXferAck) begin
          st_next.snap = timerCountIn; // whole word in one edge
          st_next.copyReq = 1'b0;
          st_next.xfer = XF_IDLE;
        end
      end
      // an upset one-hot code falls back to idle; pending request bits restart it
      default: begin
        st_next.xfer = XF_IDLE;
      end
    endcase

    // load capacitance stepping: one code per interval toward the target
    if (!st_reg.stepEn) begin
      st_next.capNow = st_reg.capTarget; // no stepping: apply at once
      st_next.stepCnt = STEP_ZERO;
    end else if (capReady) begin
      st_next.stepCnt = STEP_ZERO;
    end else if (st_reg.stepCnt == STEP_LAST) begin
      st_next.stepCnt = STEP_ZERO;
      if (st_reg.capNow < st_reg.capTarget) begin
        st_next.capNow = st_reg.capNow + 1'b1;
      end else begin
        st_next.capNow = st_reg.capNow - 1'b1;
      end
    end else begin
      st_next.stepCnt = st_reg.stepCnt + 1'b1;
    end

    // software writes, taken at the completing edge of the access phase
    if (wrEn) begin
      unique case (idx)
        IDX_SNAP0: st_next.snap[7:0] = wrByte;
        IDX_SNAP1: st_next.snap[15:8] = wrByte;
        IDX_SNAP2: st_next.snap[23:16] = wrByte;
        IDX_SNAP3: st_next.snap[31:24] = wrByte;
        IDX_OSC_CTRL: begin
          st_next.gain = wrByte[OSC_GAIN_BIT];
          st_next.mode = wrByte[OSC_MODE_BIT];
          st_next.bias = wrByte[OSC_BIAS_BIT];
          st_next.internal_slow_oscillator = wrByte[OSC_LFO_BIT] & LFO_PRESENT;
        end
        IDX_LOAD_CFG: begin
          st_next.stepEn = wrByte[CFG_STEP_BIT];
          st_next.capTarget = wrByte[CAP_W-1:0];
          st_next.stepCnt = STEP_ZERO;            // a new target restarts the interval
        end
        IDX_PIN_CFG: st_next.pin = wrByte;
        IDX_MATCH0: st_next.match[7:0] = wrByte;
        IDX_MATCH1: st_next.match[15:8] = wrByte;
        IDX_MATCH2: st_next.match[23:16] = wrByte;
        IDX_MATCH3: st_next.match[31:24] = wrByte;
        IDX_TIMER_REQ: begin
          // writing 0 cannot cancel a pending transfer; a 1 wins over completion
          if (wrByte[REQ_SET_BIT]) begin
            st_next.setReq = 1'b1;
          end
          if (wrByte[REQ_COPY_BIT]) begin
            st_next.copyReq = 1'b1;
          end
          st_next.matchEn = wrByte[REQ_MATCH_BIT];
        end
        default: st_next.pin = st_reg.pin;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  // every stored field clears on reset except the transfer state, which returns to idle; capacitance and pin bits also start at zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg.snap <= RST_WORD;
      st_reg.match <= RST_WORD;
      st_reg.gain <= 1'b0;
      st_reg.mode <= 1'b0;
      st_reg.bias <= 1'b0;
      st_reg.internal_slow_oscillator <= 1'b0;
      st_reg.stepEn <= 1'b0;
      st_reg.capTarget <= RST_CAP;
      st_reg.capNow <= RST_CAP;
      st_reg.stepCnt <= STEP_ZERO;
      st_reg.pin <= RST_BYTE;
      st_reg.setReq <= 1'b0;
      st_reg.copyReq <= 1'b0;
      st_reg.matchEn <= 1'b0;
      st_reg.xfer <= XF_IDLE;
      st_reg.ampMeta <= 1'b0;
      st_reg.ampSync <= 1'b0;
      st_reg.rdData <= RST_WORD;
      st_reg.slvErr <= 1'b0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // the lfo bit overrides mode, so the crystal path is active only without it
  always_comb begin
    prdata = st_reg.rdData;
    pready = psel && penable;
    pslverr = psel && penable && st_reg.slvErr;
    autoGainEnable = st_reg.gain;
    oscModeSelect = st_reg.mode;
    biasDoubleEnable = st_reg.bias;
    lowFreqOscSelect = st_reg.internal_slow_oscillator;
    crystalSourceActive = st_reg.mode && !st_reg.internal_slow_oscillator;
    crystalPinShort = st_reg.pin[PIN_SHORT_BIT];
    loadCapSetting = st_reg.capNow;
    matchValue = st_reg.match;
    matchEventEnable = st_reg.matchEn;
    timerLoadValue = st_reg.snap;
    timerLoadReq = (st_reg.xfer == XF_LOAD);
    timerCopyReq = (st_reg.xfer == XF_COPY);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking chkClk @(posedge mclk iff clkEn);
  endclocking
  default disable iff (!rst_n);

  sequence rdSetupOsc;
    setupRd && mapped && idx == IDX_OSC_CTRL;
  endsequence

  sequence rdSetupCfg;
    setupRd && mapped && idx == IDX_LOAD_CFG;
  endsequence

  sequence wrOsc;
    wrEn && idx == IDX_OSC_CTRL;
  endsequence

  chk_osc_low_zero: assert property (rdSetupOsc |=> (prdata[2:0] == 3'h0))
    else $error("oscillator control low bits not zero");

  chk_cfg_gap_zero: assert property (rdSetupCfg |=> (prdata[5:4] == 2'h0))
    else $error("configuration gap bits not zero");

  chk_gain_follow: assert property (wrOsc |=> autoGainEnable == $past(pwdata[7]))
    else $error("gain enable did not follow write");

  chk_mode_bias_write: assert property (wrOsc |=>
      (oscModeSelect == $past(pwdata[6])) && (biasDoubleEnable == $past(pwdata[5])))
    else $error("mode or bias did not follow write");

  chk_lfo_override: assert property (lowFreqOscSelect |-> !crystalSourceActive)
    else $error("crystal active while slow oscillator selected");

  chk_cap_ready: assert property (rdSetupCfg ##1 prdata[6] |->
      $past(st_reg.capNow) == $past(st_reg.capTarget))
    else $error("ready read while capacitance still stepping");

  chk_copy_whole: assert property (timerCopyReq && timerXferAck |=>
      (st_reg.snap == $past(timerCountIn)) && !timerCopyReq)
    else $error("copy did not take the whole count");

  chk_load_done: assert property (timerLoadReq && timerXferAck && !wrEn |=>
      !st_reg.setReq ##1 !timerLoadReq)
    else $error("set request not cleared after load");

  chk_load_cause: assert property ($rose(timerLoadReq) |-> $past(st_reg.setReq))
    else $error("load started without a set request");

  chk_amp_sync: assert property (oscAmplitudeValid [*3] |-> st_reg.ampSync)
    else $error("amplitude valid not reflected after sync");

endmodule : rtca_regs

`default_nettype wire

// File: testbench/rtca_far_model.sv
// timer and oscillator model at the far side of the register block
`timescale 1ns/1ps
`default_nettype none
module rtca_far_model
  import rtca_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [3:0] ackDelay, // wait before a request completes
  input wire logic oscRun, // an oscillator source is chosen
  input wire logic timerLoadReq, // load request from the block
  input wire logic timerCopyReq, // copy request from the block
  input wire logic [DATA_W-1:0] timerLoadValue, // value offered for a load
  output logic [DATA_W-1:0] timerCountIn, // running timer count
  output logic timerXferAck, // one-cycle completion pulse
  output logic oscAmplitudeValid // amplitude detector level
);
  logic [3:0] waitCnt; // cycles the current request has waited
  logic [3:0] runCnt; // cycles the source has been running
  ///////////////////////////////////////////////////////////////////////////
  // the count runs freely so a copy never sees a stale value by accident
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      waitCnt <= 4'h0;
      runCnt <= 4'h0;
      timerCountIn <= 32'h0000_0000;
      timerXferAck <= 1'b0;
      oscAmplitudeValid <= 1'b0;
    end else begin
      // whole word taken at once on a load
      if (timerXferAck && timerLoadReq) begin
        timerCountIn <= timerLoadValue;
      end else begin
        timerCountIn <= timerCountIn + 32'h0000_0001;
      end
      // slow or prompt answer, one pulse per request
      if ((timerLoadReq || timerCopyReq) && !timerXferAck && waitCnt == ackDelay) begin
        timerXferAck <= 1'b1;
        waitCnt <= 4'h0;
      end else begin
        timerXferAck <= 1'b0;
        if ((timerLoadReq || timerCopyReq) && !timerXferAck) begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
      // amplitude builds up for ten cycles, collapses at once when stopped
      if (!oscRun) begin
        runCnt <= 4'h0;
      end else if (runCnt != 4'hA) begin
        runCnt <= runCnt + 4'h1;
      end
      oscAmplitudeValid <= oscRun && runCnt == 4'hA;
    end
  end
endmodule : rtca_far_model
`default_nettype wire

// File: testbench/tb_rtc_osc_timer_alarm_regs.sv
// self-checking bench for the oscillator, timer buffer and match registers
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_osc_timer_alarm_regs
  import rtca_pkg::*;
;
  logic mclk, rst_n, clkEn, psel, penable, pwrite, pready, pslverr; // bus and control
  logic [7:0] paddr; // byte address
  logic [31:0] pwdata, prdata, matchValue, timerLoadValue, timerCountIn; // data words
  logic oscAmplitudeValid, autoGainEnable, oscModeSelect, biasDoubleEnable; // osc lines
  logic lowFreqOscSelect, crystalSourceActive, crystalPinShort, matchEventEnable; // levels
  logic timerLoadReq, timerCopyReq, timerXferAck; // timer link
  logic [3:0] loadCapSetting, ackDelay, c1, c2; // capacitance codes, ack wait
  logic [31:0] seed, a, b, cap; // random state and words
  logic [32:0] expQ[$]; // expected {pslverr, prdata} per transfer
  int errors, checked, i, j, k; // counters
  rtca_regs i_dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscAmplitudeValid(oscAmplitudeValid), .autoGainEnable(autoGainEnable),
    .oscModeSelect(oscModeSelect), .biasDoubleEnable(biasDoubleEnable),
    .lowFreqOscSelect(lowFreqOscSelect), .crystalSourceActive(crystalSourceActive),
    .crystalPinShort(crystalPinShort), .loadCapSetting(loadCapSetting),
    .matchValue(matchValue), .matchEventEnable(matchEventEnable),
    .timerLoadValue(timerLoadValue), .timerLoadReq(timerLoadReq),
    .timerCopyReq(timerCopyReq), .timerCountIn(timerCountIn), .timerXferAck(timerXferAck));
  rtca_far_model i_far (.mclk(mclk), .rst_n(rst_n), .ackDelay(ackDelay),
    .oscRun(crystalSourceActive | lowFreqOscSelect), .timerLoadReq(timerLoadReq),
    .timerCopyReq(timerCopyReq), .timerLoadValue(timerLoadValue),
    .timerCountIn(timerCountIn), .timerXferAck(timerXferAck),
    .oscAmplitudeValid(oscAmplitudeValid));
  ///////////////////////////////////////////////////////////////////////////
  // clock, 8 ns period
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // xorshift source of write data
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic close_out();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  ///////////////////////////////////////////////////////////////////////////
  // one apb transfer; expectation noted before the request goes out
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] d,
    input logic [32:0] exp);
    logic [31:0] r;
    int n;
    r = xs();
    expQ.push_back(exp);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {r[31:8], d};
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (pready) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      errors++;
      close_out();
    end
  endtask : apb
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 33'h0_0000_0000);
  endtask : wr
  task automatic rd(input logic [3:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, {25'h0, e});
  endtask : rd
  // waits for a timer request to be raised and finished, keeps a copied count
  task automatic wait_req();
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge mclk);
      if (timerXferAck && timerCopyReq) cap = timerCountIn;
      if (n > 2 && !timerLoadReq && !timerCopyReq) break;
    end
    if (n == 200) begin
      errors++;
      close_out();
    end
  endtask : wait_req
  ///////////////////////////////////////////////////////////////////////////
  // monitor: each completed transfer takes the oldest note
  always @(posedge mclk) begin
    if (psel && penable && pready) begin
      chk("apb", {pslverr, pwrite ? 32'h0 : prdata}, expQ.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    close_out();
  end
  ///////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
    clkEn = 1'b1;
    ackDelay = 4'h1;
    seed = 32'h0000BE75;
    errors = 0;
    checked = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    // the load configuration reads ready after reset: applied and target codes are both zero
    for (i = 0; i < 16; i++) begin
      apb(1'b0, i[3:0], 8'h00, {i == 4 || i > 12, 25'h0, i == 6, 6'h0});
    end
    // an unmapped write answers with an error and changes nothing
    apb(1'b1, 4'h4, 8'hFF, 33'h1_0000_0000);
    // oscillator control fields and source override
    wr(4'h5, 8'hFF);
    @(negedge mclk);
    chk("osc", {autoGainEnable, oscModeSelect, biasDoubleEnable, lowFreqOscSelect,
      crystalSourceActive}, 33'h1E);
    rd(4'h5, 8'hE8);
    repeat (20) @(posedge mclk);
    rd(4'h5, 8'hF8);
    wr(4'h5, 8'h40);
    @(negedge mclk);
    chk("osc", {autoGainEnable, oscModeSelect, biasDoubleEnable, lowFreqOscSelect,
      crystalSourceActive}, 33'h09);
    rd(4'h5, 8'h50);
    wr(4'h5, 8'h00);
    repeat (8) @(posedge mclk);
    rd(4'h5, 8'h00);
    // load capacitance: direct, then stepped
    a = xs();
    c1 = a[3:0];
    c2 = c1 ^ 4'hF;
    wr(4'h6, {4'h3, c1});
    rd(4'h6, {4'h4, c1});
    chk("cap", loadCapSetting, c1);
    wr(4'h6, {4'h8, c2});
    rd(4'h6, {4'h8, c2});
    for (k = 0; k < 2200 && loadCapSetting !== c2; k++) @(posedge mclk);
    chk("stepCycles", k > 100 && k < 2200, 33'h1);
    rd(4'h6, {4'hC, c2});
    // pin short changed by read, modify, write back
    wr(4'h7, 8'hFF);
    @(negedge mclk);
    chk("short", crystalPinShort, 33'h1);
    rd(4'h7, 8'h7F);
    wr(4'h7, 8'h7F);
    @(negedge mclk);
    chk("short", crystalPinShort, 33'h0);
    // buffer and match bytes, then load and copy through the timer
    for (k = 0; k < 2; k++) begin
      ackDelay <= k ? 4'hF : 4'h1;
      a = xs();
      b = xs();
      wr(4'hC, 8'h00);
      for (j = 0; j < 4; j++) wr(j[3:0], a[8*j+:8]);
      for (j = 0; j < 4; j++) wr(j[3:0] + 4'h8, b[8*j+:8]);
      for (j = 0; j < 4; j++) rd(j[3:0], a[8*j+:8]);
      for (j = 0; j < 4; j++) rd(j[3:0] + 4'h8, b[8*j+:8]);
      @(negedge mclk);
      chk("loadWord", timerLoadValue, a);
      chk("matchWord", matchValue, b);
      chk("idle", {timerLoadReq, timerCopyReq}, 33'h0);
      wr(4'hC, 8'h06);
      wait_req();
      rd(4'hC, 8'h04);
      chk("matchEn", matchEventEnable, 33'h1);
      wr(4'hC, 8'h05);
      wait_req();
      rd(4'hC, 8'h04);
      chk("gap", cap - a < 32'd200, 33'h1);
      for (j = 0; j < 4; j++) rd(j[3:0], cap[8*j+:8]);
    end
    // second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h8, 8'h00);
    rd(4'h0, 8'h00);
    repeat (3) @(posedge mclk);
    close_out();
  end
endmodule : tb_rtc_osc_timer_alarm_regs
`default_nettype wire
